/* File: dv/fcc_line_model.sv */
// Line-side partner: line clock and a repeating receive bit pattern
// ----------------------------------------------------------------------
// Line model
// ----------------------------------------------------------------------
module fcc_line_model (
  input  wire        run,
  input  wire [15:0] pat,
  output logic       line_clk,
  output logic       line_rx_data,
  output int         cw_cnt
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [15:0] cur;
  int          idx;
  initial begin
    line_clk = 1'b0;
    line_rx_data = 1'b1;
    cw_cnt = 0;
    idx = 0;
    forever begin
      wait (run);
      #62.5 line_clk = 1'b1;
      #62.5 line_clk = 1'b0;
      // A new pattern starts only at a word boundary, so words never tear
      if (idx == 0) begin
        cur = pat;
        cw_cnt++;
      end
      line_rx_data = cur[15 - idx];
      idx = (idx + 1) % 16;
    end
  end
endmodule

/* File: dv/fcc_monitor.sv */
// Port checker for the code controller
// ----------------------------------------------------------------------
// Checker
// ----------------------------------------------------------------------
module fcc_monitor (
  input wire       clk,
  input wire       arst_n,
  input wire [1:0] tx_mode,
  input wire       line_tx_data,
  input wire       tx_active,
  input wire       rx_code_detected,
  input wire       rx_idle,
  input wire       rx_locked,
  input wire       rx_fifo_empty,
  input wire [2:0] rx_fifo_level,
  input wire [5:0] rx_code_fifo_out,
  input wire       rx_fifo_read,
  input wire       rx_fifo_overflow,
  input wire       rx_overflow_clear
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  // Long enough for a truncated codeword bit to leave the line
  logic [4:0] quiet;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) quiet <= 5'h0;
    else if (tx_active) quiet <= 5'h0;
    else if (quiet != 5'h1f) quiet <= quiet + 5'h1;
  end
  empty_flag_a: assert property (rx_fifo_empty == (rx_fifo_level == 3'h0))
    else $error("empty flag disagrees with level");
  fifo_bound_a: assert property (rx_fifo_level <= 3'h4)
    else $error("fifo level above four");
  level_hold_a: assert property (!rx_fifo_read && !$rose(rx_code_detected)
    |=> $stable(rx_fifo_level)) else $error("level moved without cause");
  pop_one_a: assert property (rx_fifo_read && !rx_fifo_empty && !$rose(rx_code_detected)
    |=> rx_fifo_level == $past(rx_fifo_level) - 3'h1) else $error("read did not pop one");
  empty_read_a: assert property (rx_fifo_read && rx_fifo_empty && !$rose(rx_code_detected)
    |=> rx_fifo_empty && $stable(rx_code_fifo_out)) else $error("empty read changed fifo");
  push_one_a: assert property ($rose(rx_code_detected) && rx_fifo_level < 3'h4 && !rx_fifo_read
    |=> rx_fifo_level == $past(rx_fifo_level) + 3'h1) else $error("detected code not stored");
  full_drop_a: assert property ($rose(rx_code_detected) && rx_fifo_level == 3'h4 && !rx_fifo_read
    |=> rx_fifo_overflow && rx_fifo_level == 3'h4) else $error("full fifo not flagged");
  ovf_sticky_a: assert property (rx_fifo_overflow && !rx_overflow_clear |=> rx_fifo_overflow)
    else $error("overflow dropped");
  idle_clears_a: assert property ($rose(rx_idle) |-> !rx_code_detected)
    else $error("idle kept detection");
  det_ends_idle_a: assert property ($rose(rx_code_detected) |-> !rx_idle && rx_locked)
    else $error("detection without lock or with idle");
  cont_active_a: assert property (tx_mode == 2'h3 [*3] |-> tx_active)
    else $error("continuous mode stopped");
  idle_ones_a: assert property (quiet == 5'h1f |-> line_tx_data)
    else $error("idle output not ones");
endmodule

bind fcc_controller fcc_monitor i_fcc_monitor (.clk(clk), .arst_n(arst_n), .tx_mode(tx_mode),
  .line_tx_data(line_tx_data), .tx_active(tx_active), .rx_code_detected(rx_code_detected),
  .rx_idle(rx_idle), .rx_locked(rx_locked), .rx_fifo_empty(rx_fifo_empty),
  .rx_fifo_level(rx_fifo_level), .rx_code_fifo_out(rx_code_fifo_out),
  .rx_fifo_read(rx_fifo_read), .rx_fifo_overflow(rx_fifo_overflow),
  .rx_overflow_clear(rx_overflow_clear));

/* File: dv/tb.sv */
// Self-checking bench for the code controller
// ----------------------------------------------------------------------
// Bench
// ----------------------------------------------------------------------
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed {logic [1:0] m; logic [5:0] p; logic [5:0] s; logic [4:0] np;
    logic [4:0] ns;} fcc_tx_row;
  fcc_tx_row   tx_rows [3] = '{'{2'h1, 6'h0b, 6'h00, 5'h0a, 5'h00},
    '{2'h2, 6'h34, 6'h19, 5'h0a, 5'h0a}, '{2'h3, 6'h26, 6'h00, 5'h0c, 5'h00}};
  logic [5:0]  rx_code [5] = '{6'h12, 6'h0d, 6'h25, 6'h1a, 6'h2c};
  logic        clk = 1'b0;
  logic        arst_n, line_clk, line_rx_data, line_tx_data, tx_active, rx_code_detected;
  logic        rx_idle, rx_locked, rx_fifo_empty, rx_fifo_read, rx_fifo_overflow;
  logic        rx_overflow_clear, run;
  logic [1:0]  tx_mode;
  logic [5:0]  tx_primary_code, tx_secondary_code, rx_code_fifo_out;
  logic [2:0]  rx_fifo_level;
  logic [15:0] pat, w;
  int          cw_cnt, err_total = 0, cmp_count = 0;

  always #5 clk = ~clk;

  fcc_controller i_fcc_controller (.clk(clk), .arst_n(arst_n), .line_clk(line_clk),
    .line_rx_data(line_rx_data), .line_tx_data(line_tx_data), .tx_mode(tx_mode),
    .tx_primary_code(tx_primary_code), .tx_secondary_code(tx_secondary_code),
    .tx_active(tx_active), .rx_code_detected(rx_code_detected), .rx_idle(rx_idle),
    .rx_locked(rx_locked), .rx_fifo_empty(rx_fifo_empty), .rx_fifo_level(rx_fifo_level),
    .rx_code_fifo_out(rx_code_fifo_out), .rx_fifo_read(rx_fifo_read),
    .rx_fifo_overflow(rx_fifo_overflow), .rx_overflow_clear(rx_overflow_clear));
  fcc_line_model i_fcc_line_model (.run(run), .pat(pat), .line_clk(line_clk),
    .line_rx_data(line_rx_data), .cw_cnt(cw_cnt));

  function automatic logic [15:0] cw(input logic [5:0] c);
    return {1'b0, c[0], c[1], c[2], c[3], c[4], c[5], 1'b0, 8'hff};
  endfunction
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Returns ten clk cycles after the n-th new word starts, well after the last bit of the word before it has been judged
  task automatic words(input int n);
    int w0;
    w0 = cw_cnt;
    wait (cw_cnt == w0 + n);
    repeat (10) @(posedge clk);
  endtask
  task automatic grab(input int n);
    repeat (n) begin
      @(negedge line_clk);
      w = {w[14:0], line_tx_data};
    end
  endtask
  task automatic pulse_read;
    @(posedge clk) rx_fifo_read <= 1'b1;
    @(posedge clk) rx_fifo_read <= 1'b0;
    @(posedge clk);
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    #400us;
    err_total++;
    report_and_stop;
  end

  initial begin
    arst_n = 1'b0;
    tx_mode = 2'h0;
    tx_primary_code = 6'h00;
    tx_secondary_code = 6'h00;
    rx_fifo_read = 1'b0;
    rx_overflow_clear = 1'b0;
    run = 1'b1;
    pat = 16'hffff;
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    for (int r = 0; r < 3; r++) begin
      @(posedge clk) tx_mode <= 2'h0;
      words(1);
      @(posedge clk) begin
        tx_mode <= tx_rows[r].m;
        tx_primary_code <= tx_rows[r].p;
        tx_secondary_code <= tx_rows[r].s;
      end
      do @(negedge line_clk); while (line_tx_data !== 1'b0);
      w = 16'h0;
      grab(15);
      for (int k = 0; k < tx_rows[r].np + tx_rows[r].ns; k++) begin
        if (k > 0) grab(16);
        chk(w, cw(k < tx_rows[r].np ? tx_rows[r].p : tx_rows[r].s));
      end
      grab(16);
      chk(w, tx_rows[r].m == 2'h3 ? cw(tx_rows[r].p) : 16'hffff);
      chk(tx_active, tx_rows[r].m == 2'h3);
      $display("tx row %0d done", r);
    end
    chk(rx_idle, 1'b1);
    for (int r = 0; r < 5; r++) begin
      pat = cw(rx_code[r]);
      words(1);
      words(2);
      chk(rx_code_detected, 1'b0);
      words(1);
      chk(rx_code_detected, 1'b1);
      chk(rx_locked, 1'b1);
      chk(rx_idle, 1'b0);
      chk(rx_fifo_level, r < 4 ? r + 1 : 4);
      chk(rx_fifo_overflow, r == 4);
      $display("rx code %0d done", r);
    end
    // Drain with the line clock stopped: the read side must not need it
    run = 1'b0;
    for (int k = 0; k < 4; k++) begin
      chk(rx_code_fifo_out, rx_code[k]);
      chk(rx_fifo_level, 4 - k);
      pulse_read;
    end
    chk(rx_fifo_empty, 1'b1);
    pulse_read;
    chk(rx_fifo_level, 3'h0);
    @(posedge clk) rx_overflow_clear <= 1'b1;
    @(posedge clk) rx_overflow_clear <= 1'b0;
    $display("fifo drain done");
    run = 1'b1;
    pat = 16'hffff;
    words(2);
    chk(rx_idle, 1'b1);
    chk(rx_code_detected, 1'b0);
    chk(rx_locked, 1'b0);
    chk(rx_fifo_overflow, 1'b0);
    $display("idle return done");
    @(posedge clk) arst_n <= 1'b0;
    repeat (3) @(posedge clk);
    chk(line_tx_data, 1'b1);
    chk(tx_active, 1'b0);
    chk(rx_fifo_empty, 1'b1);
    chk(rx_idle, 1'b0);
    @(posedge clk) begin
      arst_n <= 1'b1;
      tx_mode <= 2'h0;
    end
    repeat (3) @(posedge clk);
    chk(line_tx_data, 1'b1);
    chk(tx_active, 1'b0);
    chk(rx_fifo_level, 3'h0);
    $display("reset test done");
    report_and_stop;
  end
endmodule

/* File: rtl/fcc_controller.v */
// Code controller top with its receive code FIFO
//
// Summary of operation
// R1 - Codes go LSB first on the wire; first bit sits in bit 0, last in bit 5.
// R2 - Primary and secondary transmit codes; bit 0 serialized first, bit 5 last.
// R3 - Four transmit modes; idle mode sends constant all ones.
// R4 - Single mode sends the primary codeword ten times, then all ones.
// R5 - Dual mode sends primary ten times, secondary ten times, then all ones.
// R6 - Continuous mode repeats primary until software picks another mode.
// R7 - Codeword is zero, six code bits, zero, eight ones; both directions.
// R8 - Receiver hunts every bit position for a codeword; checks code after lock.
// R9 - Same code in three clean codewords sets detected and stores it in FIFO.
// R10 - Detected clears on two consecutive differing codewords or on idle.
// R11 - Idle declared after sixteen ones; ends when detected sets.
// R12 - FIFO holds four codes, tracks fill level, shows empty to processor.
// R13 - Validated code arriving while FIFO full is dropped; overflow declared.
// R14 - Reading an empty FIFO changes nothing.
// R15 - FIFO usable from either side while the other side's clock is stopped; both sides run on clk, so only reads work with the line clock stopped.
// R16 - Reading a non-empty FIFO returns oldest code and lowers level by one.

`include "fcc_defines.vh"

// ----------------------------------------------------------------------
// Receive code FIFO
// ----------------------------------------------------------------------
module fcc_fifo #(
  parameter WIDTH = `FCC_CODE_W,
  parameter DEPTH = `FCC_FIFO_DEPTH,
  parameter AW    = `FCC_FIFO_AW
) (
  input  wire             clk,
  input  wire             arst_n,
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data,
  output reg  [AW:0]      level
);

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr;
  reg [AW-1:0]    rd_ptr;
  wire            do_wr;
  wire            do_rd;

  assign in_ready  = (level != DEPTH[AW:0]);
  assign out_valid = (level != {(AW+1){1'b0}});
  assign out_data  = mem[rd_ptr];
  assign do_wr     = in_valid & in_ready;
  // Empty reads fall out here, leaving pointers and level alone
  assign do_rd     = out_ready & out_valid; // R14

  genvar gi;
  generate
    for (gi = 0; gi < DEPTH; gi = gi + 1) begin : g_mem
      always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
          mem[gi] <= {WIDTH{1'b0}};
        end else if (do_wr && (wr_ptr == gi[AW-1:0])) begin
          mem[gi] <= in_data;
        end
      end
    end
  endgenerate

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      level  <= {(AW+1){1'b0}};
    end else begin
      if (do_wr) begin
        wr_ptr <= wr_ptr + 1'b1; // R12
      end
      if (do_rd) begin
        rd_ptr <= rd_ptr + 1'b1; // R16
      end
      if (do_wr && !do_rd) begin
        level <= level + 1'b1; // R12
      end else if (do_rd && !do_wr) begin
        level <= level - 1'b1; // R16
      end
    end
  end

endmodule

// ----------------------------------------------------------------------
// Controller top
// ----------------------------------------------------------------------
module fcc_controller (
  input  wire                   clk,
  input  wire                   arst_n,
  input  wire                   line_clk,
  input  wire                   line_rx_data,
  output reg                    line_tx_data,
  input  wire [1:0]             tx_mode,
  input  wire [`FCC_CODE_W-1:0] tx_primary_code,
  input  wire [`FCC_CODE_W-1:0] tx_secondary_code,
  output wire                   tx_active,
  output reg                    rx_code_detected,
  output reg                    rx_idle,
  output reg                    rx_locked,
  output wire                   rx_fifo_empty,
  output wire [`FCC_FIFO_AW:0]  rx_fifo_level,
  output wire [`FCC_CODE_W-1:0] rx_code_fifo_out,
  input  wire                   rx_fifo_read,
  output reg                    rx_fifo_overflow,
  input  wire                   rx_overflow_clear
);

  localparam ST_ONES = 2'h0;
  localparam ST_PRI  = 2'h1;
  localparam ST_SEC  = 2'h2;

  // --------------------------------------------------------------------
  // Line clock and data sampling
  // --------------------------------------------------------------------
  // The line clock is slow against clk, so one system clock samples both
  // sides; the FIFO never depends on line edges to be read, only to be written.
  reg  lclk_s1;
  reg  lclk_s2;
  reg  lclk_s3;
  reg  lclk_level;
  reg  ldat_s1;
  reg  ldat_s2;
  reg  ldat_s3;
  wire line_rise;

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      lclk_s1    <= 1'b0;
      lclk_s2    <= 1'b0;
      lclk_s3    <= 1'b0;
      lclk_level <= 1'b0;
      ldat_s1    <= 1'b1;
      ldat_s2    <= 1'b1;
      ldat_s3    <= 1'b1;
    end else begin
      lclk_s1 <= line_clk;
      lclk_s2 <= lclk_s1;
      lclk_s3 <= lclk_s2;
      ldat_s1 <= line_rx_data;
      ldat_s2 <= ldat_s1;
      ldat_s3 <= ldat_s2;
      if (lclk_s2 == lclk_s3) begin
        lclk_level <= lclk_s3;
      end
    end
  end

  assign line_rise = (lclk_s2 == lclk_s3) & lclk_s3 & ~lclk_level;

  // --------------------------------------------------------------------
  // Transmit codeword generator
  // --------------------------------------------------------------------
  reg  [1:0]             tx_state;
  reg  [3:0]             tx_bit;
  reg  [3:0]             tx_rep;
  reg  [1:0]             mode_q;
  reg  [`FCC_CODE_W-1:0] tx_code;
  reg                    cw_bit;
  wire                   mode_chg;

  assign mode_chg  = (tx_mode != mode_q);
  assign tx_active = (tx_state != ST_ONES);

  always @* begin
    tx_code = (tx_state == ST_SEC) ? tx_secondary_code : tx_primary_code; // R2
    if (tx_bit == `FCC_CW_ZERO_A || tx_bit == `FCC_CW_ZERO_B) begin
      cw_bit = 1'b0; // R7
    end else if (tx_bit >= `FCC_CW_ONES_FROM) begin
      cw_bit = 1'b1; // R7
    end else begin
      // Register bit 0 leaves first, right after the leading zero
      cw_bit = tx_code[tx_bit[2:0] - 3'h1]; // R1
    end
  end

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tx_state     <= ST_ONES;
      tx_bit       <= 4'h0;
      tx_rep       <= 4'h0;
      mode_q       <= `FCC_MODE_IDLE;
      line_tx_data <= 1'b1;
    end else begin
      mode_q <= tx_mode;
      if (mode_chg) begin
        // A new mode restarts the codeword at once, cutting off the one in progress
        tx_bit   <= 4'h0;
        tx_rep   <= 4'h0;
        tx_state <= (tx_mode == `FCC_MODE_IDLE) ? ST_ONES : ST_PRI; // R3
      end else if (line_rise) begin
        line_tx_data <= (tx_state == ST_ONES) ? 1'b1 : cw_bit; // R3
        tx_bit       <= tx_bit + 4'h1;
        if (tx_bit == `FCC_CW_LAST && tx_state != ST_ONES) begin
          if (mode_q == `FCC_MODE_CONT) begin
            tx_rep <= 4'h0; // R6
          end else if (tx_rep == `FCC_TX_REPEAT_LAST) begin
            tx_rep <= 4'h0;
            if (tx_state == ST_PRI && mode_q == `FCC_MODE_DUAL) begin
              tx_state <= ST_SEC; // R5
            end else begin
              tx_state <= ST_ONES; // R4
            end
          end else begin
            tx_rep <= tx_rep + 4'h1; // R4
          end
        end
      end
    end
  end

  // --------------------------------------------------------------------
  // Receive codeword alignment
  // --------------------------------------------------------------------
  reg  [15:0]            rx_sh;
  reg  [15:0]            next_sh;
  reg  [3:0]             rx_bit;
  reg  [4:0]             ones_cnt;
  reg                    cw_good;
  reg                    eval;
  reg  [`FCC_CODE_W-1:0] new_code;

  always @* begin
    next_sh  = {rx_sh[14:0], ldat_s3};
    cw_good  = ~next_sh[15] & ~next_sh[8] & (&next_sh[7:0]); // R7
    // Oldest code bit lands in bit 0
    new_code = {next_sh[9], next_sh[10], next_sh[11],
                next_sh[12], next_sh[13], next_sh[14]}; // R1
    // Hunt at every bit until locked, then only at each boundary
    eval     = line_rise & (rx_locked ? (rx_bit == `FCC_CW_LAST) : cw_good); // R8
  end

  // --------------------------------------------------------------------
  // Receive validation and idle detection
  // --------------------------------------------------------------------
  reg  [`FCC_CODE_W-1:0] cand_code;
  reg  [`FCC_CODE_W-1:0] det_code;
  reg  [1:0]             rpt_cnt;
  reg  [1:0]             diff_cnt;
  reg                    push;
  reg  [`FCC_CODE_W-1:0] push_code;
  reg  [1:0]             next_rpt;
  wire                   fifo_in_ready;
  wire                   idle_hit;

  assign idle_hit = line_rise & ldat_s3 & (ones_cnt == `FCC_IDLE_ONES - 5'h1);

  always @* begin
    if (cw_good && cand_code == new_code && rpt_cnt != `FCC_DET_COUNT) begin
      next_rpt = rpt_cnt + 2'h1;
    end else if (cw_good && cand_code == new_code) begin
      next_rpt = rpt_cnt;
    end else if (cw_good) begin
      next_rpt = 2'h1;
    end else begin
      next_rpt = 2'h0;
    end
  end

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rx_sh            <= 16'hffff;
      rx_bit           <= 4'h0;
      rx_locked        <= 1'b0;
      ones_cnt         <= 5'h00;
      rx_idle          <= 1'b0;
      rx_code_detected <= 1'b0;
      cand_code        <= 6'h00;
      det_code         <= 6'h00;
      rpt_cnt          <= 2'h0;
      diff_cnt         <= 2'h0;
      push             <= 1'b0;
      push_code        <= 6'h00;
    end else begin
      push <= 1'b0;
      if (line_rise) begin
        rx_sh  <= next_sh;
        rx_bit <= eval ? 4'h0 : rx_bit + 4'h1;
        if (!ldat_s3) begin
          ones_cnt <= 5'h00;
        end else if (ones_cnt != `FCC_IDLE_ONES) begin
          ones_cnt <= ones_cnt + 5'h01;
        end
      end
      if (eval) begin
        rx_locked <= cw_good; // R8
        rpt_cnt   <= next_rpt;
        if (cw_good) begin
          cand_code <= new_code;
        end
        if (rx_code_detected && cw_good && new_code == det_code) begin
          diff_cnt <= 2'h0;
        end else if (rx_code_detected) begin
          // Errored codewords count as differing too
          diff_cnt <= diff_cnt + 2'h1; // R10
        end
      end
      if (idle_hit) begin
        rx_idle          <= 1'b1; // R11
        rx_code_detected <= 1'b0; // R10
        diff_cnt         <= 2'h0;
      end else if (eval && next_rpt == `FCC_DET_COUNT &&
                   !(rx_code_detected && det_code == new_code)) begin
        rx_code_detected <= 1'b1; // R9
        rx_idle          <= 1'b0; // R11
        det_code         <= new_code;
        diff_cnt         <= 2'h0;
        push             <= 1'b1; // R9
        push_code        <= new_code;
      end else if (eval && rx_code_detected &&
                   !(cw_good && new_code == det_code) &&
                   diff_cnt == `FCC_DIFF_COUNT - 2'h1) begin
        rx_code_detected <= 1'b0; // R10
        diff_cnt         <= 2'h0;
      end
    end
  end

  // --------------------------------------------------------------------
  // Receive FIFO and overflow flag
  // --------------------------------------------------------------------
  // Both sides sit on clk, so a stopped line clock never blocks reads
  fcc_fifo #(
    .WIDTH (`FCC_CODE_W),
    .DEPTH (`FCC_FIFO_DEPTH),
    .AW    (`FCC_FIFO_AW)
  ) u_fifo (
    .clk       (clk),
    .arst_n    (arst_n),
    .in_valid  (push),
    .in_ready  (fifo_in_ready),
    .in_data   (push_code),
    .out_valid (),
    .out_ready (rx_fifo_read),
    .out_data  (rx_code_fifo_out),
    .level     (rx_fifo_level)
  ); // R15

  assign rx_fifo_empty = (rx_fifo_level == {(`FCC_FIFO_AW+1){1'b0}}); // R12

  // A set in the clearing cycle wins so no overflow goes unseen
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rx_fifo_overflow <= 1'b0;
    end else if (push && !fifo_in_ready) begin
      rx_fifo_overflow <= 1'b1; // R13
    end else if (rx_overflow_clear) begin
      rx_fifo_overflow <= 1'b0;
    end
  end

endmodule

/* File: rtl/fcc_defines.vh */
// Constants for the far-end alarm and control code controller
`ifndef FCC_DEFINES_VH
`define FCC_DEFINES_VH

// ----------------------------------------------------------------------
// Code and codeword layout
// ----------------------------------------------------------------------
`define FCC_CODE_W        6
`define FCC_CW_LEN        16
`define FCC_CW_LAST       4'hf
`define FCC_CW_ZERO_A     4'h0
`define FCC_CW_ZERO_B     4'h7
`define FCC_CW_ONES_FROM  4'h8

// ----------------------------------------------------------------------
// Transmit modes and repeat count
// ----------------------------------------------------------------------
`define FCC_MODE_IDLE     2'h0
`define FCC_MODE_SINGLE   2'h1
`define FCC_MODE_DUAL     2'h2
`define FCC_MODE_CONT     2'h3
`define FCC_TX_REPEAT_LAST 4'h9

// ----------------------------------------------------------------------
// Receive validation counts
// ----------------------------------------------------------------------
`define FCC_DET_COUNT     2'h3
`define FCC_DIFF_COUNT    2'h2
`define FCC_IDLE_ONES     5'h10

// ----------------------------------------------------------------------
// Receive FIFO
// ----------------------------------------------------------------------
`define FCC_FIFO_DEPTH    4
`define FCC_FIFO_AW       2

`endif
